// file: aumf_base.sv
// Base-side authentication message engine: builds, parses and checks
//
// Functional notes
// - Messages open with type code: 0x40 request, 0x41 reply
// - Handset request holds selection and challenge with handset random value
// - Base request holds selection, seed and challenge with base random value
// - Handset reply holds first response; base reply holds seed, second response
// - Response in handset request only for key allocation, else omitted
// - Element codes: challenge 0x0C, response 0x0D, seed 0x0E
// - Selection element code 0x0A, five bytes long, picks keys and algorithms
// - Standard algorithm: challenge 10, response 6, seed 10 bytes
// - Top value bit goes to bit 8 of octet 3
// - Value bit 0 goes to bit 1 of last content octet
// - Element lengths depend on algorithm; fixed only for standard one
// - Base gets seed, challenge and expected response, then sends request
// - Base compares received first response to expected; drops call on mismatch
// - Handset sends challenge request; base returns seed and second response
// - First response and cipher key come from session key, base challenge
// - Second response comes from second session key, handset challenge
`timescale 1ns/1ps
`include "aumf_map.svh"
module aumf_base
   import aumf_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        alg_std,
   input  wire logic        start_auth,
   input  wire logic        abort,
   input  wire logic [23:0] auth_sel,
   input  wire logic [63:0] seed_in,
   input  wire logic [63:0] chal_in,
   input  wire logic [31:0] exp_first_resp,
   input  wire logic        resp2_valid,
   input  wire logic [31:0] resp2_in,
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   output logic             tx_last,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_last,
   output logic             busy,
   output logic             auth_ok,
   output logic             call_drop,
   output logic             fmt_err,
   output logic             hs_chal_valid,
   output logic [63:0]      hs_chal,
   output logic [23:0]      hs_sel,
   output logic             hs_resp_present,
   output logic [31:0]      hs_resp
);
   // ------------------------------------------
   // Frame builders
   // ------------------------------------------
   function automatic aumf_frame_t mk_req(input logic [23:0] sel,
                                          input logic [63:0] rs,
                                          input logic [63:0] rn);
      mk_req = {`AUMF_MT_REQ,
                `AUMF_EI_ATYPE, `AUMF_LI_ATYPE, sel,
                `AUMF_EI_SEED,  `AUMF_LI_SEED,  rs,
                `AUMF_EI_CHAL,  `AUMF_LI_CHAL,  rn};
   endfunction : mk_req

   function automatic aumf_frame_t mk_rep(input logic [63:0] rs,
                                          input logic [31:0] rv);
      mk_rep = {`AUMF_MT_REP,
                `AUMF_EI_SEED, `AUMF_LI_SEED, rs,
                `AUMF_EI_RESP, `AUMF_LI_RESP, rv,
                `AUMF_REP_PAD};
   endfunction : mk_rep

   // Frame fully handed to the link
   function automatic logic tx_drained(input logic ld,
                                       input logic bz);
      tx_drained = !ld && !bz;
   endfunction : tx_drained

   // ------------------------------------------
   // State
   // ------------------------------------------
   typedef struct packed
   {
      aumf_st_t    st;
      aumf_frame_t frame;
      logic [4:0]  nbytes;
      logic        load;
      logic [31:0] xres;
      logic [63:0] seed;
      logic        ok;
      logic        drop;
      logic        ferr;
      logic        cvld;
      logic [63:0] hchal;
      logic [23:0] hsel;
      logic        hrp;
      logic [31:0] hres;
      aumf_ph_t    wph;
      logic [7:0]  wei;
      logic [7:0]  wcnt;
      logic [23:0] wsel;
      logic        bsy;
   } aumf_base_t;

   aumf_base_t s_q;
   aumf_base_t s_d;

   logic        tx_busy;
   logic        rx_done;
   logic [7:0]  rx_mt;
   logic [63:0] rx_chal;
   logic [63:0] rx_seed;
   logic [31:0] rx_resp;
   logic [3:0]  rx_seen;
   logic        rx_lerr;

   // ------------------------------------------
   // Serializer and parser
   // ------------------------------------------
   aumf_tx u_tx
   (
      .core_clk (core_clk),
      .rstn     (rstn),
      .load     (s_q.load),
      .frame    (s_q.frame),
      .nbytes   (s_q.nbytes),
      .tx_ready (tx_ready),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_last  (tx_last),
      .busy     (tx_busy)
   );

   aumf_rx u_rx
   (
      .core_clk (core_clk),
      .rstn     (rstn),
      .alg_std  (alg_std),
      .rx_valid (rx_valid),
      .rx_data  (rx_data),
      .rx_last  (rx_last),
      .done     (rx_done),
      .mtype    (rx_mt),
      .chal     (rx_chal),
      .seed     (rx_seed),
      .resp     (rx_resp),
      .seen     (rx_seen),
      .len_err  (rx_lerr)
   );

   // ------------------------------------------
   // Exchange sequencer
   // ------------------------------------------
   always_comb
   begin
      s_d      = s_q;
      s_d.load = 1'b0;
      s_d.ok   = 1'b0;
      s_d.drop = 1'b0;
      s_d.ferr = 1'b0;
      s_d.cvld = 1'b0;
      // Selection content walk; the parser leaves this element unread
      if (rx_valid)
      begin
         case (s_q.wph)
            AUMF_P_TYPE:
            begin
               s_d.wsel = 24'h000000;
               s_d.wph  = AUMF_P_EI;
            end
            AUMF_P_EI:
            begin
               s_d.wei = rx_data;
               s_d.wph = AUMF_P_LEN;
            end
            AUMF_P_LEN:
            begin
               s_d.wcnt = rx_data;
               s_d.wph  = (rx_data == 8'h00) ? AUMF_P_EI : AUMF_P_BODY;
            end
            AUMF_P_BODY:
            begin
               if (s_q.wei == `AUMF_EI_ATYPE)
                  s_d.wsel = {s_q.wsel[15:0], rx_data};
               s_d.wcnt = s_q.wcnt - 8'h01;
               if (s_q.wcnt == 8'h01)
                  s_d.wph = AUMF_P_EI;
            end
            default:
               s_d.wph = AUMF_P_TYPE;
         endcase
         if (rx_last)
            s_d.wph = AUMF_P_TYPE;
      end
      case (s_q.st)
         AUMF_IDLE:
         begin
            // Incoming handset request wins over a local start
            if (rx_done && rx_mt == `AUMF_MT_REQ)
            begin
               if (rx_lerr || !rx_seen[0] || !rx_seen[3])
                  s_d.ferr = 1'b1;
               else
               begin
                  s_d.hchal = rx_chal;
                  s_d.hsel  = s_q.wsel;
                  s_d.hrp   = rx_seen[2];
                  s_d.hres  = rx_resp;
                  s_d.cvld  = 1'b1;
                  s_d.st    = AUMF_WRES;
               end
            end
            else if (start_auth)
            begin
               // Seed, challenge and expected value come from the key side
               s_d.xres   = exp_first_resp;
               s_d.frame  = mk_req(auth_sel, seed_in, chal_in);
               s_d.nbytes = `AUMF_REQ_BYTES;
               s_d.load   = 1'b1;
               s_d.st     = AUMF_REQTX;
            end
         end
         AUMF_REQTX:
         begin
            if (tx_drained(s_q.load, tx_busy))
               s_d.st = AUMF_WREP;
         end
         AUMF_WREP:
         begin
            if (rx_done && rx_mt == `AUMF_MT_REP)
            begin
               if (rx_lerr || !rx_seen[2])
               begin
                  s_d.ferr = 1'b1;
                  s_d.drop = 1'b1;
               end
               else if (rx_resp == s_q.xres)
                  s_d.ok = 1'b1;
               else
                  s_d.drop = 1'b1;
               s_d.st = AUMF_IDLE;
            end
         end
         AUMF_WRES:
         begin
            // Key side supplies seed and second response
            if (resp2_valid)
            begin
               s_d.frame  = mk_rep(seed_in, resp2_in);
               s_d.nbytes = `AUMF_REP_BYTES;
               s_d.load   = 1'b1;
               s_d.st     = AUMF_REPTX;
            end
         end
         AUMF_REPTX:
         begin
            if (tx_drained(s_q.load, tx_busy))
               s_d.st = AUMF_IDLE;
         end
         default:
            s_d.st = AUMF_IDLE;
      endcase
      if (abort && s_q.st != AUMF_REQTX && s_q.st != AUMF_REPTX)
      begin
         s_d.st   = AUMF_IDLE;
         s_d.load = 1'b0;
         s_d.cvld = 1'b0;
      end
      // Registered so busy leaves a flip-flop
      s_d.bsy = (s_d.st != AUMF_IDLE);
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q    <= '0;
         s_q.st <= AUMF_IDLE;
         s_q.wph <= AUMF_P_TYPE;
      end
      else
         s_q <= s_d;
   end

   // ------------------------------------------
   // Outputs
   // ------------------------------------------
   assign busy            = s_q.bsy;
   assign auth_ok         = s_q.ok;
   assign call_drop       = s_q.drop;
   assign fmt_err         = s_q.ferr;
   assign hs_chal_valid   = s_q.cvld;
   assign hs_chal         = s_q.hchal;
   assign hs_sel          = s_q.hsel;
   assign hs_resp_present = s_q.hrp;
   assign hs_resp         = s_q.hres;
endmodule : aumf_base

// file: aumf_map.svh
// Message codes, element codes, element lengths and frame sizes
`ifndef AUMF_MAP_SVH
`define AUMF_MAP_SVH
`define AUMF_MT_REQ    8'h40
`define AUMF_MT_REP    8'h41
`define AUMF_EI_CHAL   8'h0C
`define AUMF_EI_RESP   8'h0D
`define AUMF_EI_SEED   8'h0E
`define AUMF_EI_ATYPE  8'h0A
`define AUMF_LI_CHAL   8'h08
`define AUMF_LI_RESP   8'h04
`define AUMF_LI_SEED   8'h08
`define AUMF_LI_ATYPE  8'h03
`define AUMF_REQ_BYTES 5'h1A
`define AUMF_REP_BYTES 5'h11
`define AUMF_REP_PAD   72'h0
`endif

// file: aumf_pkg.sv
// Types shared by the authentication message framer
package aumf_pkg;
   typedef enum logic [4:0]
   {
      AUMF_IDLE  = 5'h01,
      AUMF_REQTX = 5'h02,
      AUMF_WREP  = 5'h04,
      AUMF_WRES  = 5'h08,
      AUMF_REPTX = 5'h10
   } aumf_st_t;
   typedef enum logic [3:0]
   {
      AUMF_P_TYPE = 4'h1,
      AUMF_P_EI   = 4'h2,
      AUMF_P_LEN  = 4'h4,
      AUMF_P_BODY = 4'h8
   } aumf_ph_t;
   typedef logic [207:0] aumf_frame_t;
endpackage : aumf_pkg

// file: aumf_tx.sv
// Byte serializer for one outgoing message
`timescale 1ns/1ps
`include "aumf_map.svh"
module aumf_tx
   import aumf_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        load,
   input  wire aumf_frame_t frame,
   input  wire logic [4:0]  nbytes,
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   output logic             tx_last,
   output logic             busy
);
   typedef struct packed
   {
      aumf_frame_t sh;
      logic [4:0]  left;
      logic        vld;
      logic        last;
   } aumf_tx_t;
   aumf_tx_t s_q;
   aumf_tx_t s_d;
   // ------------------------------------------
   // Shift out most significant byte first
   // ------------------------------------------
   always_comb
   begin
      s_d = s_q;
      if (load && !s_q.vld)
      begin
         s_d.sh   = frame;
         s_d.left = nbytes;
         s_d.vld  = (nbytes != 5'h00);
         s_d.last = (nbytes == 5'h01);
      end
      else if (s_q.vld && tx_ready)
      begin
         s_d.sh   = {s_q.sh[199:0], 8'h00};
         s_d.left = s_q.left - 5'h01;
         s_d.vld  = (s_q.left != 5'h01);
         s_d.last = (s_q.left == 5'h02);
      end
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign tx_valid = s_q.vld;
   assign tx_data  = s_q.sh[207:200];
   assign tx_last  = s_q.last;
   assign busy     = s_q.vld;
endmodule : aumf_tx

// file: aumf_rx.sv
// Parser for one incoming message
`timescale 1ns/1ps
`include "aumf_map.svh"
module aumf_rx
   import aumf_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        alg_std,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_last,
   output logic             done,
   output logic [7:0]       mtype,
   output logic [63:0]      chal,
   output logic [63:0]      seed,
   output logic [31:0]      resp,
   output logic [3:0]       seen,
   output logic             len_err
);
   typedef struct packed
   {
      aumf_ph_t    ph;
      logic [7:0]  ei;
      logic [7:0]  cnt;
      logic [7:0]  mt;
      logic [63:0] chal;
      logic [63:0] seed;
      logic [31:0] resp;
      logic [3:0]  seen;
      logic        lerr;
      logic        done;
   } aumf_rx_t;
   aumf_rx_t s_q;
   aumf_rx_t s_d;
   // Expected length indicator for the standard algorithm
   function automatic logic [7:0] exp_li(input logic [7:0] ei);
      case (ei)
         `AUMF_EI_CHAL:  exp_li = `AUMF_LI_CHAL;
         `AUMF_EI_SEED:  exp_li = `AUMF_LI_SEED;
         `AUMF_EI_RESP:  exp_li = `AUMF_LI_RESP;
         `AUMF_EI_ATYPE: exp_li = `AUMF_LI_ATYPE;
         default:        exp_li = 8'h00;
      endcase
   endfunction : exp_li
   // ------------------------------------------
   // Element walk: identifier, length, content
   // ------------------------------------------
   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (rx_valid)
      begin
         case (s_q.ph)
            AUMF_P_TYPE:
            begin
               s_d.mt   = rx_data;
               s_d.seen = 4'h0;
               s_d.lerr = 1'b0;
               s_d.ph   = AUMF_P_EI;
            end
            AUMF_P_EI:
            begin
               s_d.ei = rx_data;
               s_d.ph = AUMF_P_LEN;
            end
            AUMF_P_LEN:
            begin
               s_d.cnt = rx_data;
               s_d.ph  = (rx_data == 8'h00) ? AUMF_P_EI : AUMF_P_BODY;
               if (alg_std && exp_li(s_q.ei) != 8'h00 && rx_data != exp_li(s_q.ei))
                  s_d.lerr = 1'b1;
            end
            AUMF_P_BODY:
            begin
               // First content byte carries the top value bits
               case (s_q.ei)
                  `AUMF_EI_CHAL: s_d.chal = {s_q.chal[55:0], rx_data};
                  `AUMF_EI_SEED: s_d.seed = {s_q.seed[55:0], rx_data};
                  `AUMF_EI_RESP: s_d.resp = {s_q.resp[23:0], rx_data};
                  default:       s_d.cnt  = s_q.cnt;
               endcase
               case (s_q.ei)
                  `AUMF_EI_CHAL:  s_d.seen[0] = 1'b1;
                  `AUMF_EI_SEED:  s_d.seen[1] = 1'b1;
                  `AUMF_EI_RESP:  s_d.seen[2] = 1'b1;
                  `AUMF_EI_ATYPE: s_d.seen[3] = 1'b1;
                  default:        s_d.seen    = s_q.seen;
               endcase
               s_d.cnt = s_q.cnt - 8'h01;
               if (s_q.cnt == 8'h01)
                  s_d.ph = AUMF_P_EI;
            end
            default:
               s_d.ph = AUMF_P_TYPE;
         endcase
         if (rx_last)
         begin
            s_d.ph   = AUMF_P_TYPE;
            s_d.done = 1'b1;
            if (s_q.ph == AUMF_P_LEN || (s_q.ph == AUMF_P_BODY && s_q.cnt != 8'h01))
               s_d.lerr = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q    <= '0;
         s_q.ph <= AUMF_P_TYPE;
      end
      else
         s_q <= s_d;
   end
   assign done    = s_q.done;
   assign mtype   = s_q.mt;
   assign chal    = s_q.chal;
   assign seed    = s_q.seed;
   assign resp    = s_q.resp;
   assign seen    = s_q.seen;
   assign len_err = s_q.lerr;
endmodule : aumf_rx

// file: aumf_base_properties.sv
// Concurrent checks on the base-side authentication message engine
`timescale 1ns/1ps
module aumf_base_properties
   import aumf_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rstn,
   input wire logic       start_auth,
   input wire logic       resp2_valid,
   input wire logic       tx_ready,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_last,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_last,
   input wire logic       busy,
   input wire logic       auth_ok,
   input wire logic       call_drop,
   input wire logic       fmt_err,
   input wire logic       hs_chal_valid
);
   logic [4:0] cnt_q;
   logic [7:0] rtyp_q;
   logic       rfst_q;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // Byte count of the outgoing frame and type byte of the incoming one
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
      begin
         cnt_q  <= 5'h00;
         rtyp_q <= 8'h00;
         rfst_q <= 1'b1;
      end
      else
      begin
         if (tx_valid && tx_ready)
            cnt_q <= tx_last ? 5'h00 : cnt_q + 5'h01;
         if (rx_valid && rfst_q)
            rtyp_q <= rx_data;
         if (rx_valid)
            rfst_q <= rx_last;
      end

   property p_req; !busy && start_auth && !rx_valid && !$past(rx_last) |-> ##2 tx_valid && tx_data == 8'h40; endproperty
   a_req: assert property (p_req) else $error("request did not open with type");
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last); endproperty
   a_hold: assert property (p_hold) else $error("tx byte dropped");
   property p_last; tx_valid && tx_ready && tx_last |-> (cnt_q == 5'h19 ##1 busy) or (cnt_q == 5'h10 ##2 !busy); endproperty
   a_last: assert property (p_last) else $error("frame length wrong");
   property p_judge; busy && rx_valid && rx_last && rtyp_q == 8'h41 |-> ##2 (auth_ok ^ call_drop) && !busy; endproperty
   a_judge: assert property (p_judge) else $error("reply not judged");
   property p_hs; !busy && rx_valid && rx_last && rtyp_q == 8'h40 |-> ##2 hs_chal_valid ^ fmt_err; endproperty
   a_hs: assert property (p_hs) else $error("handset request not handled");
   property p_reply; hs_chal_valid ##[1:8] $rose(resp2_valid) |-> ##2 tx_valid && tx_data == 8'h41; endproperty
   a_reply: assert property (p_reply) else $error("reply not started");
   property p_pulse; auth_ok || call_drop |=> !auth_ok && !call_drop; endproperty
   a_pulse: assert property (p_pulse) else $error("verdict longer than a cycle");
   property p_txbusy; tx_valid |-> busy; endproperty
   a_txbusy: assert property (p_txbusy) else $error("tx while idle");
   c_ok: cover property (auth_ok);
   c_drop: cover property (call_drop);
   c_hs: cover property (hs_chal_valid);
endmodule : aumf_base_properties

bind aumf_base aumf_base_properties u_props (.core_clk, .rstn, .start_auth, .resp2_valid,
   .tx_ready, .tx_valid, .tx_data, .tx_last, .rx_valid, .rx_data, .rx_last, .busy,
   .auth_ok, .call_drop, .fmt_err, .hs_chal_valid);

// file: aumf_hs_model.sv
// Behavioural handset-side engine that answers and originates messages
`timescale 1ns/1ps
module aumf_hs_model
(
   input  wire logic       core_clk,
   input  wire logic       slow,
   input  wire logic       bad,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_last,
   output logic            hs_drop
);
   logic [7:0]  got[$];
   logic [7:0]  frm[$];
   logic [7:0]  msg[$];
   logic [63:0] c;
   logic [63:0] bc;
   logic [31:0] r;
   logic        pend;

   // Stand-ins for the two response processes and their session keys
   function automatic logic [31:0] f1(input logic [63:0] v);
      return v[63:32] ^ v[31:0] ^ 32'h5A5A0F0F;
   endfunction : f1
   function automatic logic [31:0] f2(input logic [63:0] v);
      return v[63:32] + v[31:0] + 32'h3C3CA5A5;
   endfunction : f2
   function automatic void put(ref logic [7:0] q[$], input logic [63:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
         q.push_back(v[8 * i +: 8]);
   endfunction : put

   task automatic send(input logic [7:0] q[$]);
      foreach (q[i])
      begin
         @(negedge core_clk);
         rx_valid = 1'b1;
         rx_data  = q[i];
         rx_last  = (i == q.size() - 1);
      end
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      rx_data  = ~rx_data;
   endtask : send

   task automatic hs_req(input logic [63:0] v, input logic wr, input logic [31:0] rv,
                         input logic [7:0] len);
      c   = v;
      msg = {8'h40, 8'h0A, 8'h03, 8'h01, 8'h02, 8'h03, 8'h0C, len};
      put(msg, v, int'(len));
      if (wr)
         msg = {msg, 8'h0D, 8'h04, rv[31:24], rv[23:16], rv[15:8], rv[7:0]};
      send(msg);
   endtask : hs_req

   always @(posedge core_clk)
      if (tx_valid && tx_ready)
      begin
         got.push_back(tx_data);
         if (tx_last)
         begin
            frm  = got;
            got  = {};
            pend = (frm[0] == 8'h40);
            if (frm[0] == 8'h41)
               hs_drop = ({frm[13], frm[14], frm[15], frm[16]} !== f2(c));
         end
      end

   initial
   begin
      {tx_ready, rx_valid, rx_last, hs_drop, pend} = 5'h00;
      rx_data = 8'h00;
      forever
      begin
         @(negedge core_clk);
         tx_ready = slow ? 1'($urandom) : 1'b1;
         if (pend)
         begin
            pend = 1'b0;
            for (int i = 18; i < 26; i++)
               bc = {bc[55:0], frm[i]};
            r   = f1(bc) ^ 32'(bad);
            msg = {8'h41, 8'h0D, 8'h04, r[31:24], r[23:16], r[15:8], r[7:0]};
            send(msg);
         end
      end
   end
endmodule : aumf_hs_model

// file: aumf_base_tb.sv
// Self-checking bench for the base-side authentication message engine
`timescale 1ns/1ps
module aumf_base_tb;
   logic        core_clk, rstn, alg_std, start_auth, abort, resp2_valid, slow, bad;
   logic        tx_ready, tx_valid, tx_last, rx_valid, rx_last, busy, auth_ok;
   logic        call_drop, fmt_err, hs_chal_valid, hs_resp_present, hs_drop;
   logic [7:0]  tx_data, rx_data;
   logic [23:0] auth_sel, hs_sel;
   logic [63:0] seed_in, chal_in, hs_chal, c;
   logic [31:0] exp_first_resp, resp2_in, hs_resp, rv;
   logic [7:0]  e[$];
   int          n_errors, check_count, cyc, n_v;

   aumf_base dut (.core_clk, .rstn, .alg_std, .start_auth, .abort, .auth_sel, .seed_in,
      .chal_in, .exp_first_resp, .resp2_valid, .resp2_in, .tx_ready, .tx_valid, .tx_data,
      .tx_last, .rx_valid, .rx_data, .rx_last, .busy, .auth_ok, .call_drop, .fmt_err,
      .hs_chal_valid, .hs_chal, .hs_sel, .hs_resp_present, .hs_resp);
   aumf_hs_model hs (.core_clk, .slow, .bad, .tx_valid, .tx_data, .tx_last, .tx_ready,
      .rx_valid, .rx_data, .rx_last, .hs_drop);

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      check_count++;
      if (g !== x)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
         n_errors++;
      end
   endtask : chk

   task automatic chk_frame();
      chk(hs.frm.size(), e.size());
      foreach (e[i])
         chk(hs.frm[i], e[i]);
   endtask : chk_frame

   task automatic wait_for(input logic idle);
      for (int i = 0; i < 300; i++)
      begin
         if (idle ? busy === 1'b0 : (auth_ok | call_drop | hs_chal_valid | fmt_err) === 1'b1)
            break;
         @(negedge core_clk);
      end
   endtask : wait_for

   initial
   begin
      {rstn, alg_std, start_auth, abort, resp2_valid, slow, bad} = 7'h00;
      {auth_sel, seed_in, chal_in, exp_first_resp, resp2_in} = 216'h0;
      void'($urandom(83));
      repeat (2) @(negedge core_clk);
      rstn    = 1'b1;
      alg_std = 1'b1;
      chk(busy, 1'b0);
      chk(tx_valid, 1'b0);
      $display("test reset done");
      for (int k = 0; k < 6; k++)
      begin
         auth_sel       = 24'($urandom);
         seed_in        = {$urandom, $urandom};
         chal_in        = {$urandom, $urandom};
         exp_first_resp = hs.f1(chal_in);
         {bad, slow}    = 2'(k);
         start_auth     = 1'b1;
         @(negedge core_clk);
         start_auth = 1'b0;
         wait_for(1'b0);
         chk(auth_ok, !bad);
         chk(call_drop, bad);
         e = {8'h40, 8'h0A, 8'h03};
         hs.put(e, auth_sel, 3);
         e = {e, 8'h0E, 8'h08};
         hs.put(e, seed_in, 8);
         e = {e, 8'h0C, 8'h08};
         hs.put(e, chal_in, 8);
         chk_frame();
      end
      $display("test handset authentication done");
      {bad, slow} = 2'h0;
      chal_in     = ~chal_in;
      start_auth  = 1'b1;
      @(negedge core_clk);
      start_auth = 1'b0;
      abort      = 1'b1;
      wait_for(1'b1);
      abort = 1'b0;
      e = e[0:17];
      hs.put(e, chal_in, 8);
      chk_frame();
      repeat (12)
      begin
         @(negedge core_clk);
         if ((auth_ok | call_drop | hs_chal_valid) !== 1'b0)
            n_v++;
      end
      chk(n_v, 0);
      $display("test abort done");
      for (int k = 0; k < 4; k++)
      begin
         c    = {$urandom, $urandom};
         rv   = $urandom;
         slow = k[0];
         hs.hs_req(c, k[0], rv, 8'h08);
         wait_for(1'b0);
         chk(hs_chal_valid, 1'b1);
         chk(hs_chal, c);
         chk(hs_sel, 24'h010203);
         chk(hs_resp_present, k[0]);
         chk(k[0] ? hs_resp : rv, rv);
         seed_in  = {$urandom, $urandom};
         resp2_in = hs.f2(c) ^ 32'(k[1]);
         @(negedge core_clk);
         resp2_valid = 1'b1;
         @(negedge core_clk);
         resp2_valid = 1'b0;
         wait_for(1'b1);
         e = {8'h41, 8'h0E, 8'h08};
         hs.put(e, seed_in, 8);
         e = {e, 8'h0D, 8'h04};
         hs.put(e, resp2_in, 4);
         chk_frame();
         chk(hs_drop, k[1]);
      end
      $display("test base authentication done");
      hs.hs_req(c, 1'b0, rv, 8'h07);
      wait_for(1'b0);
      chk(fmt_err, 1'b1);
      chk(hs_chal_valid, 1'b0);
      $display("test malformed done");
      alg_std = 1'b0;
      hs.hs_req(c, 1'b0, rv, 8'h07);
      wait_for(1'b0);
      chk(hs_chal_valid, 1'b1);
      chk(hs_chal[55:0], c[55:0]);
      abort = 1'b1;
      @(negedge core_clk);
      abort = 1'b0;
      chk(busy, 1'b0);
      $display("test lenient lengths done");
      wrap_up();
   end
endmodule : aumf_base_tb
